// ===== rtl/ctsf_pkg.sv
// Operation
// (RULE1) Timeout code writes select 60 to 510 minutes in 30-minute steps; default 1011.
// (RULE2) Reading the timeout field returns remaining time in 2048-second units.
// (RULE3) Timeout field writes take effect only while the security key is unlocked.
// (RULE4) Timer loads at charge start, halts while paused, reloads on fast-select toggle.
// (RULE5) Timer expiry sets the timeout flag and terminates charging.
// (RULE6) State code at 13:12 reads 00 off, 01 trickle, 10 fast, never 11.
// (RULE7) Indicator pin, when assigned, is an open-drain LED sink.
// (RULE8) Indicator keeps the LED off whenever charger current is zero; code drops the sink one cycle after current stops.
// (RULE9) Indicator blinks at 0.5 Hz during trickle charging.
// (RULE10) Indicator blinks at 1 Hz during fast charging.
// (RULE11) Blink uses equal on and off time from a divided clock.
// (RULE12) Faults are handled autonomously and raise the matching flag.
// (RULE13) Thermistor below cold limit sets the battery-cold flag.
// (RULE14) Thermistor above hot limit sets the battery-hot flag.
// (RULE15) Charging is suspended while hot or cold condition is present.
// (RULE16) Suspended trickle charge restarts once temperature returns to normal.
// (RULE17) Thermistor-presence enable at bit 3, default 1; cleared ignores absence.
// (RULE18) Hot enable at bit 2, default 1; cleared ignores over-temperature entirely.
// (RULE19) Cold enable at bit 1, default 1; cleared ignores under-temperature entirely.
// (RULE20) Monitor enables writable only with user key unlocked; read-only in ROM configs.
// (RULE21) Host keeps temperature monitoring enabled unless battery lacks a thermistor.
// (RULE22) Hot, cold and timeout flags set on rising edge, clear when read.
package ctsf_pkg;
    localparam logic [7:0] CFG1_IDX = 8'ha8;
    localparam logic [7:0] CFG2_IDX = 8'ha9;
    localparam logic [7:0] CTRL_IDX = 8'hb0;
    localparam logic [7:0] FLAG_IDX = 8'hb1;
    localparam logic [7:0] KEY_IDX = 8'hb2;
    localparam logic [11:0] CFG1_ADDR = {2'h0, CFG1_IDX, 2'h0};
    localparam logic [11:0] CFG2_ADDR = {2'h0, CFG2_IDX, 2'h0};
    localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_IDX, 2'h0};
    localparam logic [11:0] FLAG_ADDR = {2'h0, FLAG_IDX, 2'h0};
    localparam logic [11:0] KEY_ADDR = {2'h0, KEY_IDX, 2'h0};
    // Key values are arbitrary
    localparam logic [15:0] SEC_KEY_VAL = 16'h00c3;
    localparam logic [15:0] USER_KEY_VAL = 16'h005a;
    localparam int MON_LSB = 1;
    localparam logic [2:0] MON_RST = 3'h7;
    localparam int TIME_LSB = 8;
    localparam logic [3:0] TIME_RST = 4'hb;
    localparam int STS_LSB = 12;
    localparam int REM_LSB = 11;
    localparam logic [14:0] BASE_S = 15'h0e10;
    localparam logic [14:0] STEP_S = 15'h0708;
    localparam int CTL_EN = 0;
    localparam int CTL_FAST = 1;
    localparam int CTL_HOLD = 2;
    localparam int CTL_IND = 3;
    localparam int FLG_TO = 0;
    localparam int FLG_COLD = 1;
    localparam int FLG_HOT = 2;
    localparam int CLK_PERIOD_NS = 40;
    localparam int SECOND_NS = 1000000000;
    localparam int QUARTER_NS = 250000000;
    localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int QTR_CYCLES = QUARTER_NS / CLK_PERIOD_NS;
    typedef enum logic [1:0] {ST_OFF, ST_TRICKLE, ST_FAST, ST_DONE} ctsf_chg_t;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ctsf_apb_req_t;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } ctsf_apb_rsp_t;
    typedef struct packed {
        logic pwr_ok;
        logic therm_hot;
        logic therm_cold;
        logic thermistor_absent;
        logic rom_config;
    } ctsf_sense_t;
    typedef struct packed {
        ctsf_chg_t st;
        logic [14:0] remain;
        logic [24:0] sec_cnt;
        logic [22:0] qtr_cnt;
        logic [2:0] phase;
        logic [3:0] limit;
        logic [2:0] mon_en;
        logic [3:0] ctrl;
        logic [2:0] flags;
        logic sec_key;
        logic user_key;
        logic hot_d;
        logic cold_d;
        logic fast_d;
        ctsf_apb_rsp_t rsp;
        logic oe;
        logic chg_on;
        logic fast_on;
    } ctsf_state_t;
    function automatic logic [14:0] lim_secs(input logic [3:0] code);
        lim_secs = BASE_S + 15'(code * STEP_S);
    endfunction : lim_secs
endpackage : ctsf_pkg

// ===== rtl/ctsf_top.sv
`timescale 1ns/1ps
module ctsf_top #(
    parameter int SEC_CYC = ctsf_pkg::SEC_CYCLES,
    parameter int QTR_CYC = ctsf_pkg::QTR_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // APB slave
    input wire ctsf_pkg::ctsf_apb_req_t apb_req,
    output ctsf_pkg::ctsf_apb_rsp_t apb_rsp,
    // Analogue sense levels
    input wire ctsf_pkg::ctsf_sense_t sense,
    // Charger drive
    output logic charge_current_en,
    output logic fast_mode,
    // Indicator pin, open drain
    input wire logic charge_indicator_out_i,
    output logic charge_indicator_out_o,
    output logic charge_indicator_out_oe
);
    ctsf_pkg::ctsf_state_t s;
    ctsf_pkg::ctsf_state_t n;
    logic hot_cond;
    logic cold_cond;
    logic absent_cond;
    logic suspend;
    logic hold;
    logic active;
    logic tick_s;
    logic tick_q;
    logic setup;
    logic acc;
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rdata;
    logic [2:0] clr;
    logic [2:0] set;

    assign hot_cond = sense.therm_hot & s.mon_en[ctsf_pkg::CTL_FAST]; // RULE18
    assign cold_cond = sense.therm_cold & s.mon_en[ctsf_pkg::CTL_EN]; // RULE19
    assign absent_cond = sense.thermistor_absent & s.mon_en[ctsf_pkg::CTL_HOLD]; // RULE17
    // Absence without a flag: the battery is simply not charged
    assign suspend = hot_cond | cold_cond | absent_cond; // RULE15 RULE12
    assign hold = s.ctrl[ctsf_pkg::CTL_HOLD];
    assign active = (s.st == ctsf_pkg::ST_TRICKLE) || (s.st == ctsf_pkg::ST_FAST);
    assign tick_s = s.sec_cnt == 25'(SEC_CYC - 1);
    assign tick_q = s.qtr_cnt == 23'(QTR_CYC - 1);
    assign setup = apb_req.psel & ~apb_req.penable;
    assign acc = apb_req.psel & apb_req.penable & s.rsp.pready;
    assign wr = acc & apb_req.pwrite;
    assign rd = acc & ~apb_req.pwrite;

    always_comb begin
        hit = 1'b1;
        rdata = 32'h0;
        unique case (apb_req.paddr)
            ctsf_pkg::CFG1_ADDR: begin
                rdata[ctsf_pkg::MON_LSB +: 3] = s.mon_en;
            end
            ctsf_pkg::CFG2_ADDR: begin
                rdata[ctsf_pkg::TIME_LSB +: 4] = s.remain[ctsf_pkg::REM_LSB +: 4]; // RULE2
                rdata[ctsf_pkg::STS_LSB +: 2] = !s.chg_on ? 2'h0 :
                    (s.fast_on ? 2'h2 : 2'h1); // RULE6
            end
            ctsf_pkg::CTRL_ADDR: begin
                rdata[3:0] = s.ctrl;
                rdata[8] = charge_indicator_out_i;
            end
            ctsf_pkg::FLAG_ADDR: begin
                rdata[2:0] = s.flags;
            end
            ctsf_pkg::KEY_ADDR: begin
                rdata[1:0] = {s.user_key, s.sec_key};
            end
            default: begin
                hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        n = s;
        clr = 3'h0;
        set = 3'h0;
        // Bus answers in the cycle after setup; no wait states
        n.rsp.pready = setup;
        n.rsp.pslverr = setup & ~hit;
        n.rsp.prdata = (setup & ~apb_req.pwrite) ? rdata : 32'h0;
        if (wr) begin
            unique case (apb_req.paddr)
                ctsf_pkg::CFG1_ADDR: begin
                    if (s.user_key && !sense.rom_config) begin
                        n.mon_en = apb_req.pwdata[ctsf_pkg::MON_LSB +: 3]; // RULE20
                    end
                end
                ctsf_pkg::CFG2_ADDR: begin
                    if (s.sec_key) begin
                        n.limit = apb_req.pwdata[ctsf_pkg::TIME_LSB +: 4]; // RULE3 RULE1
                    end
                end
                ctsf_pkg::CTRL_ADDR: begin
                    n.ctrl = apb_req.pwdata[3:0];
                end
                ctsf_pkg::KEY_ADDR: begin
                    n.sec_key = apb_req.pwdata[15:0] == ctsf_pkg::SEC_KEY_VAL;
                    n.user_key = apb_req.pwdata[15:0] == ctsf_pkg::USER_KEY_VAL;
                end
                default: begin
                end
            endcase
        end
        // Only bits actually returned are cleared, so a late event survives
        if (rd && apb_req.paddr == ctsf_pkg::FLAG_ADDR) begin
            clr = s.rsp.prdata[2:0]; // RULE22
        end
        n.hot_d = hot_cond;
        n.cold_d = cold_cond;
        n.fast_d = s.ctrl[ctsf_pkg::CTL_FAST];
        set[ctsf_pkg::FLG_HOT] = hot_cond & ~s.hot_d; // RULE14 RULE22
        set[ctsf_pkg::FLG_COLD] = cold_cond & ~s.cold_d; // RULE13 RULE22
        n.sec_cnt = tick_s ? 25'h0 : s.sec_cnt + 25'h1;
        n.qtr_cnt = tick_q ? 23'h0 : s.qtr_cnt + 23'h1;
        n.phase = tick_q ? s.phase + 3'h1 : s.phase; // RULE11
        unique case (s.st)
            ctsf_pkg::ST_OFF: begin
                if (s.ctrl[ctsf_pkg::CTL_EN] && sense.pwr_ok) begin
                    n.st = ctsf_pkg::ST_TRICKLE;
                    n.remain = ctsf_pkg::lim_secs(s.limit); // RULE4
                end
            end
            ctsf_pkg::ST_TRICKLE, ctsf_pkg::ST_FAST: begin
                if (s.ctrl[ctsf_pkg::CTL_FAST] != s.fast_d) begin
                    n.remain = ctsf_pkg::lim_secs(s.limit); // RULE4
                end else if (tick_s && !suspend && !hold) begin // RULE4 RULE16
                    if (s.remain <= 15'h1) begin
                        n.remain = 15'h0;
                        n.st = ctsf_pkg::ST_DONE; // RULE5
                        set[ctsf_pkg::FLG_TO] = 1'b1; // RULE5
                    end else begin
                        n.remain = s.remain - 15'h1;
                    end
                end
                if (n.st != ctsf_pkg::ST_DONE) begin
                    n.st = s.ctrl[ctsf_pkg::CTL_FAST] ? ctsf_pkg::ST_FAST :
                        ctsf_pkg::ST_TRICKLE;
                end
            end
            ctsf_pkg::ST_DONE: begin
            end
        endcase
        if (!s.ctrl[ctsf_pkg::CTL_EN] || !sense.pwr_ok) begin
            n.st = ctsf_pkg::ST_OFF;
        end
        // Set wins over a same-cycle read clear
        n.flags = (s.flags & ~clr) | set;
        n.chg_on = active && (n.st != ctsf_pkg::ST_OFF) && (n.st != ctsf_pkg::ST_DONE)
            && !suspend && !hold; // RULE15 RULE16
        n.fast_on = n.st == ctsf_pkg::ST_FAST;
        n.oe = s.ctrl[ctsf_pkg::CTL_IND] & s.chg_on // RULE7 RULE8
            & (s.fast_on ? s.phase[1] : s.phase[2]); // RULE9 RULE10
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
            s.st <= ctsf_pkg::ST_OFF;
            s.limit <= ctsf_pkg::TIME_RST; // RULE1
            s.mon_en <= ctsf_pkg::MON_RST; // RULE17 RULE18 RULE19
        end else begin
            s <= n;
        end
    end

    assign apb_rsp = s.rsp;
    assign charge_current_en = s.chg_on;
    assign fast_mode = s.fast_on;
    // Pin is only ever pulled low; the LED is lit while enabled
    assign charge_indicator_out_o = 1'b0; // RULE7
    assign charge_indicator_out_oe = s.oe;

    property p_sts_code;
        @(posedge mclk) disable iff (!rstn)
        s.rsp.pready && s.rsp.prdata[ctsf_pkg::STS_LSB +: 2] == 2'h3 |-> 1'b0;
    endproperty
    a_sts_code: assert property (p_sts_code) else $error("state code 11 read"); // RULE6

    property p_hot_flag;
        @(posedge mclk) disable iff (!rstn)
        $rose(hot_cond) |=> s.flags[ctsf_pkg::FLG_HOT];
    endproperty
    a_hot_flag: assert property (p_hot_flag) else $error("hot flag missed"); // RULE14

    property p_cold_flag;
        @(posedge mclk) disable iff (!rstn)
        $rose(cold_cond) |=> s.flags[ctsf_pkg::FLG_COLD];
    endproperty
    a_cold_flag: assert property (p_cold_flag) else $error("cold flag missed"); // RULE13

    property p_led_off;
        @(posedge mclk) disable iff (!rstn)
        !s.chg_on |=> !charge_indicator_out_oe;
    endproperty
    a_led_off: assert property (p_led_off) else $error("led lit with no current"); // RULE8

    property p_timeout;
        @(posedge mclk) disable iff (!rstn)
        active && tick_s && !suspend && !hold && s.remain == 15'h1
            && s.ctrl[ctsf_pkg::CTL_FAST] == s.fast_d && s.ctrl[ctsf_pkg::CTL_EN]
            && sense.pwr_ok |=> s.flags[ctsf_pkg::FLG_TO] && s.st == ctsf_pkg::ST_DONE;
    endproperty
    a_timeout: assert property (p_timeout) else $error("timeout not taken"); // RULE5

    property p_locked;
        @(posedge mclk) disable iff (!rstn)
        !s.sec_key |=> $stable(s.limit);
    endproperty
    a_locked: assert property (p_locked) else $error("locked limit changed"); // RULE3

    property p_hot_off;
        @(posedge mclk) disable iff (!rstn)
        !s.mon_en[ctsf_pkg::CTL_FAST] && !s.flags[ctsf_pkg::FLG_HOT] |=>
            !s.flags[ctsf_pkg::FLG_HOT];
    endproperty
    a_hot_off: assert property (p_hot_off) else $error("hot flag while disabled"); // RULE18

    property p_suspend;
        @(posedge mclk) disable iff (!rstn)
        suspend |=> !charge_current_en;
    endproperty
    a_suspend: assert property (p_suspend) else $error("charging during fault"); // RULE15

    property p_hold_timer;
        @(posedge mclk) disable iff (!rstn)
        hold && active && s.ctrl[ctsf_pkg::CTL_FAST] == s.fast_d |=> $stable(s.remain);
    endproperty
    a_hold_timer: assert property (p_hold_timer) else $error("timer ran in pause"); // RULE4

    property p_rom_lock;
        @(posedge mclk) disable iff (!rstn)
        sense.rom_config || !s.user_key |=> $stable(s.mon_en);
    endproperty
    a_rom_lock: assert property (p_rom_lock) else $error("monitor enables changed"); // RULE20
endmodule : ctsf_top

// ===== verification/ctsf_led_model.sv
`timescale 1ns/1ps
module ctsf_led_model (
    // Open-drain drive from the charger
    input wire logic oe,
    input wire logic drv,
    // Pin level fed back to the charger
    output logic pin
);
    // Pull-up keeps the pin high whenever nobody sinks it
    assign pin = (oe === 1'b1 && drv === 1'b0) ? 1'b0 : 1'b1;
endmodule : ctsf_led_model

// ===== verification/charger_timer_status_fault_test.sv
`timescale 1ns/1ps
module charger_timer_status_fault_test;
    localparam logic [11:0] AC1 = ctsf_pkg::CFG1_ADDR;
    localparam logic [11:0] AC2 = ctsf_pkg::CFG2_ADDR;
    localparam logic [11:0] ACT = ctsf_pkg::CTRL_ADDR;
    localparam logic [11:0] AFL = ctsf_pkg::FLAG_ADDR;
    localparam logic [11:0] AKY = ctsf_pkg::KEY_ADDR;
    localparam int QTR = 10;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    ctsf_pkg::ctsf_apb_req_t req = '0;
    ctsf_pkg::ctsf_apb_rsp_t rsp;
    ctsf_pkg::ctsf_sense_t sense = '0;
    logic cur, fast, pin, drv, oe;
    logic [31:0] rd;
    logic err;
    int n_mismatch = 0;
    int n_checks = 0;

    always #20 mclk = ~mclk;

    // Short second and quarter counts keep blink periods and timer expiry within reach
    ctsf_top #(.SEC_CYC(4), .QTR_CYC(QTR)) ctsf_top_inst (
        .mclk(mclk), .rstn(rstn), .apb_req(req), .apb_rsp(rsp), .sense(sense),
        .charge_current_en(cur), .fast_mode(fast), .charge_indicator_out_i(pin),
        .charge_indicator_out_o(drv), .charge_indicator_out_oe(oe));
    ctsf_led_model ctsf_led_model_inst (.oe(oe), .drv(drv), .pin(pin));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    // Entered just after a rising edge; one idle cycle after release
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        req.psel <= 1'b1;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge mclk);
        req.penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) n_mismatch++;
        rd = rsp.prdata;
        err = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge mclk);
    endtask : apb

    task automatic wait_oe(input logic v, output int n);
        n = 0;
        while (oe !== v && n < 300) begin
            @(posedge mclk);
            n++;
        end
        if (n >= 300) n_mismatch++;
    endtask : wait_oe

    task automatic t_reset;
        apb(0, AC1, 0);
        chk(32'(rd[3:1]), 32'h7);
        apb(0, AC2, 0);
        chk(32'(rd[13:12]), 32'h0);
        apb(0, 12'h3fc, 0);
        chk({err, rd[30:0]}, 32'h80000000);
    endtask : t_reset

    task automatic t_timer;
        apb(1, AC2, 0);
        apb(1, ACT, 32'h1);
        // Current comes on two edges after the enable write lands
        @(posedge mclk);
        apb(0, AC2, 0);
        chk(32'(rd[13:8]), 32'h1b);
        apb(1, ACT, 0);
        apb(1, AKY, 32'hc3);
        apb(1, AC2, 0);
        apb(1, ACT, 32'h1);
        @(posedge mclk);
        apb(0, AC2, 0);
        chk(32'(rd[13:8]), 32'h11);
        apb(1, AC2, 32'hf00);
        apb(0, AC2, 0);
        chk(32'(rd[13:8]), 32'h11);
        apb(1, ACT, 32'h3);
        apb(0, AC2, 0);
        chk(32'(rd[13:8]), 32'h2e);
        chk(32'(fast), 32'h1);
        apb(1, AKY, 0);
    endtask : t_timer

    task automatic t_led;
        int n;
        apb(1, ACT, 32'hb);
        wait_oe(1, n);
        chk(32'({drv, pin}), 32'h0);
        wait_oe(0, n);
        wait_oe(1, n);
        wait_oe(0, n);
        chk(32'(n), 32'(2 * QTR));
        apb(1, ACT, 32'h9);
        wait_oe(1, n);
        wait_oe(0, n);
        wait_oe(1, n);
        wait_oe(0, n);
        chk(32'(n), 32'(4 * QTR));
        apb(1, ACT, 32'hd);
        n = 0;
        repeat (100) begin
            @(posedge mclk);
            if (oe !== 1'b0 || cur !== 1'b0) n++;
        end
        chk(32'(n), 32'h0);
        apb(1, ACT, 0);
    endtask : t_led

    task automatic set_temp(input logic h, input logic c, input logic a);
        sense.therm_hot <= h;
        sense.therm_cold <= c;
        sense.thermistor_absent <= a;
        repeat (3) @(posedge mclk);
    endtask : set_temp

    task automatic t_temp;
        logic [2:0] fe [3] = '{3'h4, 3'h2, 3'h0};
        apb(1, ACT, 32'h1);
        for (int i = 0; i < 3; i++) begin
            set_temp(i == 0, i == 1, i == 2);
            chk(32'(cur), 32'h0);
            apb(0, AFL, 0);
            chk(32'(rd[2:0]), 32'(fe[i]));
            apb(0, AFL, 0);
            chk(32'(rd[2:0]), 32'h0);
            set_temp(0, 0, 0);
            chk(32'(cur), 32'h1);
        end
        apb(1, AKY, 32'h5a);
        apb(1, AC1, 0);
        set_temp(1, 1, 1);
        chk(32'(cur), 32'h1);
        apb(0, AFL, 0);
        chk(32'(rd[2:0]), 32'h0);
        set_temp(0, 0, 0);
        // A factory ROM build must refuse even an unlocked write
        sense.rom_config <= 1'b1;
        apb(1, AC1, 32'he);
        apb(0, AC1, 0);
        chk(32'(rd[3:1]), 32'h0);
        sense.rom_config <= 1'b0;
        apb(1, AC1, 32'he);
        apb(0, AC1, 0);
        chk(32'(rd[3:1]), 32'h7);
        apb(1, AKY, 0);
        apb(1, AC1, 0);
        apb(0, AC1, 0);
        chk(32'(rd[3:1]), 32'h7);
        apb(1, ACT, 0);
    endtask : t_temp

    // Shortest limit: 3600 seconds of four cycles each
    task automatic t_timeout;
        apb(1, AKY, 32'hc3);
        apb(1, AC2, 0);
        apb(1, AKY, 0);
        apb(1, ACT, 32'h1);
        repeat (14000) @(posedge mclk);
        apb(0, AFL, 0);
        chk(32'(rd[2:0]), 32'h0);
        chk(32'(cur), 32'h1);
        repeat (500) @(posedge mclk);
        apb(0, AFL, 0);
        chk(32'(rd[2:0]), 32'h1);
        chk(32'(cur), 32'h0);
        apb(0, AC2, 0);
        chk(32'(rd[13:8]), 32'h0);
        apb(1, ACT, 0);
    endtask : t_timeout

    initial begin
        #1000000;
        n_mismatch++;
        final_report();
    end

    initial begin
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        sense.pwr_ok <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_timer();
        t_led();
        t_temp();
        t_timeout();
        final_report();
    end
endmodule : charger_timer_status_fault_test
